/* hw/pad_config_and_soft_reset_regs.sv */
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps
`include "pad_cfg_defs.svh"
// apb register bank: pad configuration, soft reset, synthesizer and fault words
module pad_config_and_soft_reset_regs (
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   // apb slave
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [17:0]              paddr,
   input  wire logic [31:0]              pwdata,
   input  wire logic [3:0]               pstrb,
   output      logic [31:0]              prdata,
   output      logic                     pready,
   output      logic                     pslverr,
   // master select pad
   output      logic                     master_select_pullup_en,
   output      logic [1:0]               master_select_edge_rate,
   output      logic [1:0]               master_select_strength,
   // master data-out pad
   output      logic                     master_dataout_pullup_en,
   output      logic [1:0]               master_dataout_edge_rate,
   output      logic [1:0]               master_dataout_strength,
   // sixth multipurpose pad
   output      logic                     mpio_six_pulldown_en,
   output      logic [1:0]               mpio_six_edge_rate,
   output      logic [1:0]               mpio_six_strength,
   // seventh multipurpose pad
   output      logic                     mpio_seven_pulldown_en,
   output      logic [1:0]               mpio_seven_edge_rate,
   output      logic [1:0]               mpio_seven_strength,
   // clock output pad
   output      logic                     clk_output_pulldown_en,
   output      logic [1:0]               clk_output_edge_rate,
   output      logic [1:0]               clk_output_strength,
   // soft reset to the rest of the device
   output      logic                     device_soft_reset,
   // synthesizer words seen by the clock block
   output      pad_cfg_pkg::ctrl_word_t  synth_control_a,
   output      pad_cfg_pkg::ctrl_word_t  synth_control_b,
   output      pad_cfg_pkg::ctrl_word_t  synth_source_select,
   // fault manager
   input  wire logic [7:0]               fault_event,
   output      logic [7:0]               fault_flags,
   // slave port mode
   input  wire logic                     spi_mode_select,
   output      logic                     slave_port_is_spi
);
   import pad_cfg_pkg::*;

   // decode state
   reg_sel_t           sel_d;            // group hit by current address
   logic [2:0]         sub_d;            // pad or synth number within group
   reg_sel_t           sel_q;            // group latched in setup
   logic [2:0]         sub_q;            // number latched in setup
   logic               err_d;            // unmapped or misaligned
   logic [15:0]        idx;              // word index from paddr

   // storage
   pad_field_t         pad_q [`PAD_COUNT];    // pad fields from the leaf registers
   pad_field_t         pad_wdata;             // merged write data for pads
   ctrl_word_t         synth_q [`SYNTH_COUNT];// synthesizer words
   logic               reinit_n_q;            // active low soft reset bit
   logic [`FAULT_W-1:0] fault_q;              // sticky fault flags
   logic               spi_mode_q;            // slave port mode latch

   // bus handshake
   logic               pready_q;
   logic               pslverr_q;
   logic [31:0]        prdata_q;
   logic               wr_fire;               // write takes effect this edge
   ctrl_word_t         rd_word;               // read mux output
   ctrl_word_t         wr_word;               // write data after byte lanes

   // merge byte lanes of a 16-bit word
   function automatic ctrl_word_t lane_merge(input ctrl_word_t old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
      ctrl_word_t r;
      r = old_v;
      if (strb[0]) begin
         r[7:0] = new_v[7:0];
      end
      if (strb[1]) begin
         r[15:8] = new_v[15:8];
      end
      return r;
   endfunction

   // widen a pad field into its 16-bit word, reserved bits zero
   function automatic ctrl_word_t pad_word(input pad_field_t f);
      return {11'h000, f};                    // [R01]
   endfunction

   assign idx = paddr[17:2];

   // address decode, if chain on word index
   always_comb begin
      sel_d = SEL_NONE;
      sub_d = 3'h0;
      if (paddr[1:0] != 2'h0) begin
         sel_d = SEL_NONE;                    // misaligned
      end else if (idx >= `IDX_MASTER_SELECT_PAD && idx <= `IDX_CLOCK_OUTPUT_PAD) begin
         sel_d = SEL_PAD;
         sub_d = 3'(idx - `IDX_MASTER_SELECT_PAD);
      end else if (idx == `IDX_SOFTWARE_REINIT) begin
         sel_d = SEL_SOFT;
      end else if (idx >= `IDX_SYNTH_FIRST && idx <= `IDX_SYNTH_LAST) begin
         sel_d = SEL_SYNTH;
         sub_d = 3'(idx - `IDX_SYNTH_FIRST);
      end else if (idx == `IDX_FAULT_FLAGS) begin
         sel_d = SEL_FAULT;
      end
      err_d = (sel_d == SEL_NONE);
   end

   // read mux on the setup-phase address
   always_comb begin
      rd_word = 16'h0000;
      case (sel_d)
         SEL_PAD: begin
            rd_word = pad_word(pad_q[sub_d]);
         end
         SEL_SOFT: begin
            rd_word = {15'h0000, reinit_n_q}; // [R09]
         end
         SEL_SYNTH: begin
            rd_word = synth_q[sub_d];
         end
         SEL_FAULT: begin
            rd_word = {8'h00, fault_q};
         end
         default: begin
            rd_word = 16'h0000;
         end
      endcase
   end

   // write data merged against the addressed word
   always_comb begin
      wr_word = 16'h0000;
      case (sel_q)
         SEL_PAD: begin
            wr_word = lane_merge(pad_word(pad_q[sub_q]), pwdata, pstrb);
         end
         SEL_SOFT: begin
            wr_word = lane_merge({15'h0000, reinit_n_q}, pwdata, pstrb);
         end
         SEL_SYNTH: begin
            wr_word = lane_merge(synth_q[sub_q], pwdata, pstrb);
         end
         SEL_FAULT: begin
            wr_word = lane_merge(16'h0000, pwdata, pstrb);
         end
         default: begin
            wr_word = 16'h0000;
         end
      endcase
   end

   assign pad_wdata = wr_word[`PAD_FIELD_W-1:0];
   // access phase with pready up; erroring transfers write nothing
   assign wr_fire = psel & penable & pready_q & pwrite & ~pslverr_q;

   // setup phase: latch decode and read data, answer next cycle
   // one wait-free access phase keeps prdata a flop output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         sel_q     <= SEL_NONE;
         sub_q     <= 3'h0;
      end else if (psel && !penable) begin
         // bus stays alive under soft reset
         pready_q  <= 1'b1;                   // [R12]
         pslverr_q <= err_d;
         prdata_q  <= {16'h0000, rd_word};
         sel_q     <= sel_d;
         sub_q     <= sub_d;
      end else begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;

   // pad registers, one leaf each with its own default
   localparam pad_field_t PAD_RST [`PAD_COUNT] = '{
      5'(`RST_MASTER_SELECT_PAD),   // [R04]
      5'(`RST_MASTER_DATAOUT_PAD),  // [R05]
      5'(`RST_MPIO_SIX_PAD),        // [R06]
      5'(`RST_MPIO_SEVEN_PAD),      // [R07]
      5'(`RST_CLOCK_OUTPUT_PAD)     // [R08]
   };

   for (genvar i = 0; i < `PAD_COUNT; i++) begin : g_pad
      pad_field_reg #(
         .RESET_VAL (PAD_RST[i])
      ) u_pad (
         .pclk              (pclk),
         .presetn           (presetn),
         .soft_reset_active (~reinit_n_q),    // [R10]
         .wr_en             (wr_fire && sel_q == SEL_PAD && sub_q == 3'(i)),
         .wr_data           (pad_wdata),
         .cfg_q             (pad_q[i])
      );
   end

   // pad field fan-out, slices of the leaf flops
   assign master_select_pullup_en  = pad_q[0][`PAD_PULL_BIT];
   assign master_select_edge_rate  = pad_q[0][`PAD_EDGE_HI:`PAD_EDGE_LO];
   assign master_select_strength   = pad_q[0][`PAD_DRIVE_HI:`PAD_DRIVE_LO];
   assign master_dataout_pullup_en = pad_q[1][`PAD_PULL_BIT];
   assign master_dataout_edge_rate = pad_q[1][`PAD_EDGE_HI:`PAD_EDGE_LO];
   assign master_dataout_strength  = pad_q[1][`PAD_DRIVE_HI:`PAD_DRIVE_LO];
   // on the multipurpose and clock pads the pull is a pull-down
   assign mpio_six_pulldown_en     = pad_q[2][`PAD_PULL_BIT];
   assign mpio_six_edge_rate       = pad_q[2][`PAD_EDGE_HI:`PAD_EDGE_LO];
   assign mpio_six_strength        = pad_q[2][`PAD_DRIVE_HI:`PAD_DRIVE_LO];
   assign mpio_seven_pulldown_en   = pad_q[3][`PAD_PULL_BIT];
   assign mpio_seven_edge_rate     = pad_q[3][`PAD_EDGE_HI:`PAD_EDGE_LO];
   assign mpio_seven_strength      = pad_q[3][`PAD_DRIVE_HI:`PAD_DRIVE_LO];
   assign clk_output_pulldown_en   = pad_q[4][`PAD_PULL_BIT];
   assign clk_output_edge_rate     = pad_q[4][`PAD_EDGE_HI:`PAD_EDGE_LO];
   assign clk_output_strength      = pad_q[4][`PAD_DRIVE_HI:`PAD_DRIVE_LO];

   // soft reset bit, set back by the hardware reset or a software write of one
   // never cleared by its own state, otherwise software could not leave
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reinit_n_q <= 1'(`RST_SOFTWARE_REINIT);  // [R09]
      end else if (wr_fire && sel_q == SEL_SOFT) begin
         reinit_n_q <= wr_word[`SOFT_RESET_BIT]; // [R09]
      end
   end

   assign device_soft_reset = ~reinit_n_q; // [R10]

   // synthesizer words: hardware reset only, writable in soft reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int k = 0; k < `SYNTH_COUNT; k++) begin
            synth_q[k] <= `RST_SYNTH;
         end
      end else if (wr_fire && sel_q == SEL_SYNTH) begin
         synth_q[sub_q] <= wr_word;           // [R11] [R12]
      end
   end

   assign synth_control_a     = synth_q[0];
   assign synth_control_b     = synth_q[1];
   assign synth_source_select = synth_q[2];

   // fault flags: sticky, write one to clear, set wins, blind to soft reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_q <= `RST_FAULT_FLAGS;
      end else if (wr_fire && sel_q == SEL_FAULT) begin
         fault_q <= (fault_q & ~wr_word[`FAULT_W-1:0]) | fault_event; // [R11]
      end else begin
         fault_q <= fault_q | fault_event;
      end
   end

   assign fault_flags = fault_q;

   // slave mode latch: soft reset cannot return it to two-wire
   // the host must pull the hardware reset to get two-wire back
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         spi_mode_q <= 1'b0;                  // [R14]
      end else if (spi_mode_select) begin
         spi_mode_q <= 1'b1;                  // [R13]
      end
   end

   assign slave_port_is_spi = spi_mode_q;
endmodule

/* hw/pad_cfg_defs.svh */
// How it works
// R01: pad registers 16 bits, pull/slew/drive fields
// R02: slew 00 slowest..11 fastest, resets fast
// R03: drive 00 lowest..11 highest, resets lowest
// R04: master select pad resets 0x0018, pull-up on
// R05: master data-out pad resets 0x0018, pull-up on
// R06: sixth multipurpose pad resets 0x0018, pull-down on
// R07: seventh multipurpose pad resets 0x0018, pull-down on
// R08: clock output pad resets 0x0008, pull-down off
// R09: soft reset bit zero, active low, resets 1
// R10: soft reset returns control registers to defaults
// R11: synthesizer and fault registers survive soft reset
// R12: slave ports and synthesizer writes work meanwhile
// R13: serial-peripheral slave mode survives soft reset
// R14: only hardware reset restores two-wire mode
`ifndef PAD_CFG_DEFS_SVH
`define PAD_CFG_DEFS_SVH

// register indexes, byte address is four times the index
`define IDX_MASTER_SELECT_PAD  16'hf79f
`define IDX_MASTER_DATAOUT_PAD 16'hf7a0
`define IDX_MPIO_SIX_PAD       16'hf7a1
`define IDX_MPIO_SEVEN_PAD     16'hf7a2
`define IDX_CLOCK_OUTPUT_PAD   16'hf7a3
`define IDX_SOFTWARE_REINIT    16'hf890
`define IDX_SYNTH_FIRST        16'hf000
`define IDX_SYNTH_LAST         16'hf006
`define IDX_FAULT_FLAGS        16'hf8a0

// pad field positions
`define PAD_PULL_BIT   4
`define PAD_EDGE_HI    3
`define PAD_EDGE_LO    2
`define PAD_DRIVE_HI   1
`define PAD_DRIVE_LO   0
`define PAD_FIELD_W    5

// reset values
`define RST_MASTER_SELECT_PAD  16'h0018
`define RST_MASTER_DATAOUT_PAD 16'h0018
`define RST_MPIO_SIX_PAD       16'h0018
`define RST_MPIO_SEVEN_PAD     16'h0018
`define RST_CLOCK_OUTPUT_PAD   16'h0008
`define RST_SOFTWARE_REINIT    16'h0001
`define RST_SYNTH              16'h0000
`define RST_FAULT_FLAGS        8'h00

// misc
`define PAD_COUNT      5
`define SYNTH_COUNT    7
`define FAULT_W        8
`define SOFT_RESET_BIT 0

`endif

/* hw/pad_cfg_pkg.sv */
package pad_cfg_pkg;
   // register group hit by an apb address, one-hot
   typedef enum logic [4:0] {
      SEL_NONE  = 5'b00001,
      SEL_PAD   = 5'b00010,
      SEL_SOFT  = 5'b00100,
      SEL_SYNTH = 5'b01000,
      SEL_FAULT = 5'b10000
   } reg_sel_t;

   // stored part of one pad register
   typedef logic [4:0] pad_field_t;

   // one 16-bit control word
   typedef logic [15:0] ctrl_word_t;
endpackage

/* hw/pad_field_reg.sv */
`timescale 1ns/10ps
`include "pad_cfg_defs.svh"
// one pad configuration register: pull, edge rate, strength
module pad_field_reg #(
   parameter pad_cfg_pkg::pad_field_t RESET_VAL = 5'h08
) (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   soft_reset_active,
   input  wire logic                   wr_en,
   input  wire pad_cfg_pkg::pad_field_t wr_data,
   output      pad_cfg_pkg::pad_field_t cfg_q
);
   import pad_cfg_pkg::*;

   // soft reset holds the default and swallows writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= RESET_VAL;                 // [R02] [R03]
      end else if (soft_reset_active) begin
         cfg_q <= RESET_VAL;                 // [R10]
      end else if (wr_en) begin
         cfg_q <= wr_data;                   // [R01]
      end
   end
endmodule

/* verif/pad_cfg_monitor.sv */
`timescale 1ns/10ps
// protocol and soft reset checks on the bank's ports
module pad_cfg_monitor (
   input wire logic                    pclk,
   input wire logic                    presetn,
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [17:0]             paddr,
   input wire logic [31:0]             pwdata,
   input wire logic [3:0]              pstrb,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   input wire logic                    master_select_pullup_en,
   input wire logic [1:0]              master_select_edge_rate,
   input wire logic [1:0]              master_select_strength,
   input wire logic                    clk_output_pulldown_en,
   input wire logic [1:0]              clk_output_edge_rate,
   input wire logic [1:0]              clk_output_strength,
   input wire logic                    device_soft_reset,
   input wire pad_cfg_pkg::ctrl_word_t synth_control_a,
   input wire logic                    spi_mode_select,
   input wire logic                    slave_port_is_spi
);
   import pad_cfg_pkg::*;
   logic done;   // access edge of a write transfer
   logic soft_wr; // lane 0 write to the soft reset word
   logic synth_wr; // full write to synth word a
   assign done = psel && penable && pready && pwrite;
   assign soft_wr = done && paddr == 18'h3e240 && pstrb[0];
   assign synth_wr = done && paddr == 18'h3c000 && pstrb[1:0] == 2'b11;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // zero wait states: answer in the cycle after setup
   ready_after_setup_a: assert property (psel && !penable |=> pready && penable)
      else $error("no answer after setup");
   ready_one_cycle_a: assert property (pready |=> !pready)
      else $error("ready stood two cycles");
   error_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   misaligned_error_a: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
      else $error("misaligned access not refused");
   upper_read_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
   soft_bit_out_a: assert property (soft_wr |=> device_soft_reset != $past(pwdata[0]))
      else $error("soft reset output wrong polarity");
   // master select and clock output pads sit at defaults once the soft reset has settled
   pads_held_default_a: assert property (device_soft_reset [*2] |-> master_select_pullup_en &&
      master_select_edge_rate == 2'b10 && master_select_strength == 2'b00 && !clk_output_pulldown_en &&
      clk_output_edge_rate == 2'b10 && clk_output_strength == 2'b00)
      else $error("pad not at default in soft reset");
   synth_write_a: assert property (synth_wr |=> synth_control_a == $past(pwdata[15:0]))
      else $error("synth write lost");
   spi_mode_kept_a: assert property (spi_mode_select || slave_port_is_spi |=> slave_port_is_spi)
      else $error("spi mode lost");
   cover property (soft_wr && !pwdata[0]);
   cover property (device_soft_reset && synth_wr);
   cover property (pslverr);
endmodule

bind pad_config_and_soft_reset_regs pad_cfg_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .master_select_pullup_en(master_select_pullup_en),
   .master_select_edge_rate(master_select_edge_rate), .master_select_strength(master_select_strength),
   .clk_output_pulldown_en(clk_output_pulldown_en), .clk_output_edge_rate(clk_output_edge_rate),
   .clk_output_strength(clk_output_strength), .device_soft_reset(device_soft_reset),
   .synth_control_a(synth_control_a), .spi_mode_select(spi_mode_select), .slave_port_is_spi(slave_port_is_spi));

/* verif/pad_config_and_soft_reset_regs_tb.sv */
`timescale 1ns/10ps
module pad_config_and_soft_reset_regs_tb;
   import pad_cfg_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, spi_sel = 1'b0;
   logic [17:0] paddr = 18'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0]  pstrb = 4'h0;
   logic [7:0]  fault_event = 8'h00, fault_flags;
   logic        pready, pslverr, soft_out, is_spi, err;
   logic        ms_pu, md_pu, m6_pd, m7_pd, ck_pd;
   logic [1:0]  ms_er, ms_st, md_er, md_st, m6_er, m6_st, m7_er, m7_st, ck_er, ck_st;
   ctrl_word_t  syn_a, syn_b, syn_s;
   logic [15:0] wv;
   int          failures = 0, tests_run = 0, cycles = 0;
   // pad words then soft reset word, with reset values
   logic [15:0] idx_tab [6] = '{16'hf79f, 16'hf7a0, 16'hf7a1, 16'hf7a2, 16'hf7a3, 16'hf890};
   logic [15:0] rst_tab [6] = '{16'h0018, 16'h0018, 16'h0018, 16'h0018, 16'h0008, 16'h0001};

   pad_config_and_soft_reset_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .master_select_pullup_en(ms_pu), .master_select_edge_rate(ms_er),
      .master_select_strength(ms_st), .master_dataout_pullup_en(md_pu), .master_dataout_edge_rate(md_er),
      .master_dataout_strength(md_st), .mpio_six_pulldown_en(m6_pd), .mpio_six_edge_rate(m6_er),
      .mpio_six_strength(m6_st), .mpio_seven_pulldown_en(m7_pd), .mpio_seven_edge_rate(m7_er),
      .mpio_seven_strength(m7_st), .clk_output_pulldown_en(ck_pd), .clk_output_edge_rate(ck_er),
      .clk_output_strength(ck_st), .device_soft_reset(soft_out), .synth_control_a(syn_a),
      .synth_control_b(syn_b), .synth_source_select(syn_s), .fault_event(fault_event),
      .fault_flags(fault_flags), .spi_mode_select(spi_sel), .slave_port_is_spi(is_spi));

   // 100 MHz clock
   always #5 pclk = ~pclk;

   // hang guard, run needs well under this
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one apb transfer, held until ready is sampled high
   task automatic apb(input logic w, input logic [15:0] idx, input logic [1:0] lo, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, lo};
      pwdata <= d;
      pstrb <= 4'hf;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // no wait count assumed: a lost answer is ended by the hang guard
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // let registered outputs land
   task automatic settle();
      repeat (2) @(posedge pclk);
      #1;
   endtask

   // stored fields of one pad as seen on its pins
   function automatic logic [4:0] pad_out(input int i);
      case (i)
         0: return {ms_pu, ms_er, ms_st};
         1: return {md_pu, md_er, md_st};
         2: return {m6_pd, m6_er, m6_st};
         3: return {m7_pd, m7_er, m7_st};
         default: return {ck_pd, ck_er, ck_st};
      endcase
   endfunction

   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      // reset values of the pad and soft reset words and the pad pins
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, idx_tab[i], 2'b00, 32'h0);
         chk("reset value", {16'h0, rst_tab[i]}, rd);
         if (i < 5) chk("reset pins", {27'h0, rst_tab[i][4:0]}, {27'h0, pad_out(i)});
      end
      $display("test reset_values done");
      // every edge rate and strength code, reserved bits 15:11 written as ones
      for (int i = 0; i < 5; i++) begin
         wv = {11'h0, i[0], i[1:0], ~i[1:0]};
         apb(1'b1, idx_tab[i], 2'b00, {21'h1fffff, wv[10:0]});
         apb(1'b0, idx_tab[i], 2'b00, 32'h0);
         chk("pad readback", {16'h0, wv}, rd);
         chk("pad pins", {27'h0, wv[4:0]}, {27'h0, pad_out(i)});
      end
      apb(1'b0, 16'hf7a4, 2'b00, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      apb(1'b0, idx_tab[0], 2'b10, 32'h0);
      chk("misaligned error", 32'h1, {31'h0, err});
      $display("test pad_fields done");
      // soft reset with synth, fault and spi state to keep
      apb(1'b1, 16'hf000, 2'b00, 32'h1234);
      @(posedge pclk);
      fault_event <= 8'h5a;
      spi_sel <= 1'b1;
      @(posedge pclk);
      fault_event <= 8'h00;
      spi_sel <= 1'b0;
      apb(1'b1, 16'hf890, 2'b00, 32'h0);
      settle();
      chk("soft reset out", 32'h1, {31'h0, soft_out});
      for (int i = 0; i < 5; i++) chk("soft pins", {27'h0, rst_tab[i][4:0]}, {27'h0, pad_out(i)});
      apb(1'b1, idx_tab[2], 2'b00, 32'h3);
      chk("dropped write error", 32'h0, {31'h0, err});
      apb(1'b0, idx_tab[2], 2'b00, 32'h0);
      chk("held pad", 32'h18, rd);
      apb(1'b1, 16'hf001, 2'b00, 32'hbeef);
      apb(1'b1, 16'hf002, 2'b00, 32'h00a5);
      settle();
      chk("synth write in soft reset", 32'hbeef, {16'h0, syn_b});
      chk("synth source in soft reset", 32'h00a5, {16'h0, syn_s});
      chk("synth kept", 32'h1234, {16'h0, syn_a});
      apb(1'b0, 16'hf8a0, 2'b00, 32'h0);
      chk("fault kept", 32'h5a, rd);
      chk("fault pins", 32'h5a, {24'h0, fault_flags});
      apb(1'b0, 16'hf890, 2'b00, 32'h0);
      chk("soft bit", 32'h0, rd);
      chk("spi in soft reset", 32'h1, {31'h0, is_spi});
      apb(1'b1, 16'hf890, 2'b00, 32'h1);
      settle();
      chk("soft reset off", 32'h0, {31'h0, soft_out});
      chk("spi after soft reset", 32'h1, {31'h0, is_spi});
      apb(1'b0, idx_tab[0], 2'b00, 32'h0);
      chk("pad not restored", 32'h18, rd);
      $display("test soft_reset done");
      // only the reset pin brings back two-wire mode
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      settle();
      chk("spi cleared", 32'h0, {31'h0, is_spi});
      chk("synth cleared", 32'h0, {16'h0, syn_a});
      chk("synth source cleared", 32'h0, {16'h0, syn_s});
      $display("test hard_reset done");
      print_verdict();
   end
endmodule
